// ==== logic/gp_timer.sv ====
// General-purpose timer with PWM, chaining, RTC and DMA request
// Operation
// R01: PWM when alt=1, capture=0, mode=2; code also requires 16-bit config
// R02: PWM counts without prescaler
// R03: PWM counts down, reloads after zero
// R04: PWM sets no flags, no interrupt
// R05: Output on at load, off at match
// R06: Invert bit complements PWM output
// R07: Wait bit holds count until trigger
// R08: Chain follows lower-numbered module
// R09: Chain order depends on 32 or 16 bit
// R10: Software never sets wait in module 0
// R11: Chaining works in one-shot and periodic
// R12: Raw flag event raises burst DMA request
// R13: Config selects 32, RTC or 16 bit
// R14: Mode 1 one-shot, mode 2 periodic
// R15: Snapshot, wait, match trigger, direction bits
// R16: Software stops timer before reconfiguring
// R17: Flags stay until one written to clear
// R18: Match flag set, counting continues
// R19: One-shot stops, periodic reloads
// R20: System supplies RTC clock on even pin
// R21: RTC match sets flag, keeps counting
// R22: 16-bit modes use prescaler
// R23: Masked flag only when mask bit set
// R24: Idle PWM output rests inactive
// R25: Chain trigger is one-cycle pulse
`timescale 1ns/1ps
module gp_timer (
    input  wire logic                    clk,
    input  wire logic                    arst_n,
    input  wire logic                    ce,
    input  wire logic [2:0]              width_config,
    input  wire logic [1:0]              counter_run_bit,
    input  wire logic [1:0][1:0]         timer_mode_field,
    input  wire logic [1:0]              alt_mode_select,
    input  wire logic [1:0]              capture_kind_select,
    input  wire logic [1:0]              wait_chain_trigger_bit,
    input  wire logic [1:0]              snapshot_at_timeout,
    input  wire logic [1:0]              match_trigger_enable,
    input  wire logic [1:0]              match_irq_enable,
    input  wire logic [1:0]              count_direction,
    input  wire logic [1:0]              pwm_output_invert,
    input  wire logic [31:0]             interval_load_a,
    input  wire logic [15:0]             interval_load_b,
    input  wire logic [31:0]             match_value_a,
    input  wire logic [15:0]             match_value_b,
    input  wire logic [1:0][7:0]         prescale_value,
    input  wire logic [4:0]              irq_mask_word,
    input  wire logic [4:0]              irq_clear_word,
    input  wire logic                    chain_trigger_in,
    input  wire logic [1:0]              capture_compare_pin_i,
    output logic [1:0]                   capture_compare_pin_o,
    output logic [1:0]                   capture_compare_pin_oe,
    output logic                         chain_trigger_out,
    output logic [1:0]                   match_trigger,
    output logic                         dma_req,
    output logic [4:0]                   raw_irq_flags,
    output logic [4:0]                   masked_irq_flags,
    output logic                         irq,
    output logic [31:0]                  count_a,
    output logic [31:0]                  count_b,
    output logic [31:0]                  snapshot_a,
    output logic [31:0]                  snapshot_b
);
    import gp_timer_pkg::*;

    state_t                 q;
    state_t                 d;
    kind_t  [1:0]           kind;
    logic   [1:0]           to_ev;
    logic   [4:0]           set_v;
    logic                   wide;
    logic                   rtc_edge;
    logic   [31:0]          lim;
    logic   [31:0]          il;
    logic   [31:0]          mt;
    logic   [31:0]          nx;
    logic                   en;
    logic                   trig;
    logic                   tick;
    logic                   hit;

    // ========================================
    // Next-state logic
    always_comb begin
        d        = q;
        kind[0]  = K_IDLE;
        kind[1]  = K_IDLE;
        to_ev    = 2'b00;
        set_v    = 5'h00;
        lim      = LIM_16;
        il       = CNT_ZERO;
        mt       = CNT_ZERO;
        nx       = CNT_ZERO;
        en       = 1'b0;
        trig     = 1'b0;
        tick     = 1'b0;
        hit      = 1'b0;
        wide     = (width_config != CFG_16); // R13
        rtc_edge = 1'b0;
        // Pin filter: change taken once stages two and three agree
        d.sync   = {q.sync[1], q.sync[0], capture_compare_pin_i[0]};
        if (q.sync[2] == q.sync[1]) begin
            d.lvl    = q.sync[2];
            rtc_edge = q.sync[2] & ~q.lvl;
        end
        for (int h = 0; h < 2; h++) begin
            lim = (h == 0 && wide) ? LIM_32 : LIM_16;
            il  = (h == 0) ? (interval_load_a & lim)
                           : {HI_ZERO, interval_load_b};
            mt  = (h == 0) ? (match_value_a & lim)
                           : {HI_ZERO, match_value_b};
            en  = counter_run_bit[h] && (h == 0 || !wide);
            // Half B follows A; half A follows the module below
            trig = (h == 0) ? chain_trigger_in : q.to_p[0]; // R08 R09
            if (h == 0 && width_config == CFG_RTC) begin
                kind[h] = K_RTC;
            end else if (width_config == CFG_32
                         || width_config == CFG_16) begin
                if (alt_mode_select[h] && !capture_kind_select[h]
                    && timer_mode_field[h] == MODE_PWM
                    && width_config == CFG_16) begin
                    kind[h] = K_PWM; // R01
                end else if (!alt_mode_select[h]
                             && timer_mode_field[h] == MODE_ONE) begin
                    kind[h] = K_ONE; // R14
                end else if (!alt_mode_select[h]
                             && timer_mode_field[h] == MODE_PER) begin
                    kind[h] = K_PER; // R14
                end
            end
            d.run_d[h] = en;
            d.mtrig[h] = 1'b0;
            if (!en) begin
                d.armed[h] = 1'b0;
                d.done[h]  = 1'b0;
                d.pwm[h]   = 1'b0; // R24
            end else if (!q.run_d[h]) begin
                d.cnt[h]   = (count_direction[h] || kind[h] == K_RTC)
                             ? CNT_ZERO : il;
                if (kind[h] == K_PWM) begin
                    d.cnt[h] = il;
                end
                // R07 R11
                d.armed[h] = !(wait_chain_trigger_bit[h]
                               && (kind[h] == K_ONE || kind[h] == K_PER));
                d.pre[h]   = prescale_value[h];
            end else if (!q.armed[h]) begin
                d.armed[h] = trig; // R07
            end else begin
                case (kind[h])
                    K_PWM: begin
                        // R02 R03 R04
                        d.cnt[h] = (q.cnt[h] == CNT_ZERO) ? il
                                   : q.cnt[h] - CNT_ONE;
                        if (q.cnt[h] == il) begin
                            d.pwm[h] = 1'b1; // R05
                        end else if (q.cnt[h] == mt) begin
                            d.pwm[h] = 1'b0; // R05
                        end
                    end
                    K_RTC: begin
                        if (rtc_edge) begin
                            nx       = q.cnt[h] + CNT_ONE;
                            d.cnt[h] = nx;
                            if (nx == mt) begin
                                set_v[IX_RTC] = 1'b1; // R21
                            end
                        end
                    end
                    K_ONE, K_PER: begin
                        tick = 1'b1;
                        if (!wide && !q.done[h]) begin
                            // R22
                            tick = (q.pre[h] == PRE_ZERO);
                            d.pre[h] = tick ? prescale_value[h]
                                            : q.pre[h] - 8'h01;
                        end
                        if (tick && !q.done[h]) begin
                            hit = count_direction[h]
                                  ? (q.cnt[h] == il)
                                  : (q.cnt[h] == CNT_ZERO);
                            if (q.cnt[h] == mt) begin
                                // R15 R18
                                set_v[h == 0 ? IX_MT_A : IX_MT_B] =
                                    match_irq_enable[h];
                                d.mtrig[h] = match_trigger_enable[h];
                            end
                            if (hit) begin
                                to_ev[h] = 1'b1;
                                set_v[h == 0 ? IX_TO_A : IX_TO_B] = 1'b1;
                                if (snapshot_at_timeout[h]) begin
                                    d.snap[h] = q.cnt[h]; // R15
                                end
                                d.cnt[h] = count_direction[h]
                                           ? CNT_ZERO : il; // R19
                                d.done[h] = (kind[h] == K_ONE); // R19
                            end else begin
                                d.cnt[h] = (count_direction[h]
                                            ? q.cnt[h] + CNT_ONE
                                            : q.cnt[h] - CNT_ONE) & lim;
                            end
                        end
                    end
                    default: ;
                endcase
            end
            d.pin[h] = d.pwm[h] ^ pwm_output_invert[h]; // R06
        end
        // Set wins over clear
        d.raw   = (q.raw & ~irq_clear_word) | set_v; // R17
        d.dma   = |set_v; // R12
        d.chain = wide ? to_ev[0] : to_ev[1]; // R09 R25
        d.to_p  = to_ev;
    end

    // ========================================
    // State register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

    // ========================================
    // Outputs
    assign capture_compare_pin_o  = q.pin;
    assign capture_compare_pin_oe = {kind[1] == K_PWM, kind[0] == K_PWM};
    assign chain_trigger_out      = q.chain;
    assign match_trigger          = q.mtrig;
    assign dma_req                = q.dma;
    assign raw_irq_flags          = q.raw;
    assign masked_irq_flags       = q.raw & irq_mask_word; // R23
    assign irq                    = |(q.raw & irq_mask_word); // R23
    assign count_a                = q.cnt[0];
    assign count_b                = q.cnt[1];
    assign snapshot_a             = q.snap[0];
    assign snapshot_b             = q.snap[1];

    // ========================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    AST_PWM_NO_FLAGS: assert property ( // R04
        kind[0] == K_PWM |-> !set_v[IX_TO_A] && !set_v[IX_MT_A])
        else $error("flag set in PWM mode");
    AST_MASKED: assert property ( // R23
        ce && set_v[IX_TO_A]
        |=> raw_irq_flags[IX_TO_A] && (irq || !irq_mask_word[IX_TO_A]))
        else $error("raw flag or interrupt missing");
    AST_STICKY: assert property ( // R17
        ce && raw_irq_flags[IX_TO_A] && !irq_clear_word[IX_TO_A]
        |=> raw_irq_flags[IX_TO_A])
        else $error("flag lost without clear");
    AST_SET_WINS: assert property ( // R17
        ce && set_v[IX_RTC] |=> raw_irq_flags[IX_RTC])
        else $error("set lost to clear");
    AST_DMA: assert property ( // R12
        ce && |set_v |=> dma_req)
        else $error("no DMA request on event");
    AST_CHAIN: assert property ( // R09
        ce && wide && to_ev[0] |=> chain_trigger_out)
        else $error("chain pulse missing");
    AST_PWM_REST: assert property ( // R24
        ce && !counter_run_bit[0]
        |=> capture_compare_pin_o[0] == $past(pwm_output_invert[0]))
        else $error("idle PWM level wrong");
    AST_PWM_RELOAD: assert property ( // R03
        ce && kind[0] == K_PWM && q.run_d[0] && q.armed[0]
        && counter_run_bit[0] && count_a == CNT_ZERO
        |=> count_a == ($past(interval_load_a) & LIM_16))
        else $error("PWM reload wrong");
    AST_WAIT_HOLD: assert property ( // R07
        q.run_d[0] && counter_run_bit[0] && !q.armed[0]
        && !chain_trigger_in |=> $stable(count_a))
        else $error("counted while waiting");

    AST_PWM_ON: assert property ( // R05
        ce && kind[0] == K_PWM && q.run_d[0] && q.armed[0]
        && counter_run_bit[0] && count_a == (interval_load_a & LIM_16)
        |=> capture_compare_pin_o[0] != $past(pwm_output_invert[0]))
        else $error("PWM output not raised at load value");
    AST_PWM_OFF: assert property ( // R05
        ce && kind[0] == K_PWM && q.run_d[0] && q.armed[0]
        && counter_run_bit[0] && count_a == (match_value_a & LIM_16)
        && count_a != (interval_load_a & LIM_16)
        |=> capture_compare_pin_o[0] == $past(pwm_output_invert[0]))
        else $error("PWM output not dropped at match value");
    AST_ONE_STOP: assert property ( // R19
        ce && kind[0] == K_ONE && q.done[0] && counter_run_bit[0]
        |=> $stable(count_a))
        else $error("one-shot counted after time-out");

    COV_PWM:   cover property (kind[0] == K_PWM && q.pin[0] ##1 !q.pin[0]);
    COV_CHAIN: cover property (chain_trigger_out);
    COV_RTC:   cover property (set_v[IX_RTC]);
    COV_ONE:   cover property (kind[1] == K_ONE && to_ev[1]);
    COV_WAIT:  cover property (q.run_d[0] && !q.armed[0] && chain_trigger_in);
endmodule

// ==== logic/gp_timer_pkg.sv ====
// Constants and types shared by the general-purpose timer
package gp_timer_pkg;
    // ========================================
    // Width configuration codes
    localparam logic [2:0]  CFG_32     = 3'h0;
    localparam logic [2:0]  CFG_RTC    = 3'h1;
    localparam logic [2:0]  CFG_16     = 3'h4;
    // ========================================
    // Timer mode field codes
    localparam logic [1:0]  MODE_ONE   = 2'h1;
    localparam logic [1:0]  MODE_PER   = 2'h2;
    localparam logic [1:0]  MODE_PWM   = 2'h2;
    // ========================================
    // Flag bit positions
    localparam int          FLAG_W     = 5;
    localparam int          IX_TO_A    = 0;
    localparam int          IX_MT_A    = 1;
    localparam int          IX_RTC     = 2;
    localparam int          IX_TO_B    = 3;
    localparam int          IX_MT_B    = 4;
    // ========================================
    // Counter widths and limits
    localparam int          CNT_W      = 32;
    localparam int          HALF_W     = 16;
    localparam int          PRE_W      = 8;
    localparam logic [31:0] LIM_16     = 32'h0000ffff;
    localparam logic [31:0] LIM_32     = 32'hffffffff;
    localparam logic [31:0] CNT_ZERO   = 32'h00000000;
    localparam logic [31:0] CNT_ONE    = 32'h00000001;
    localparam logic [15:0] HI_ZERO    = 16'h0000;
    localparam logic [7:0]  PRE_ZERO   = 8'h00;

    typedef enum logic [2:0] {
        K_IDLE = 3'b000,
        K_ONE  = 3'b001,
        K_PER  = 3'b010,
        K_PWM  = 3'b011,
        K_RTC  = 3'b100
    } kind_t;

    typedef struct packed {
        logic [1:0][31:0] cnt;
        logic [1:0][7:0]  pre;
        logic [1:0][31:0] snap;
        logic [1:0]       armed;
        logic [1:0]       done;
        logic [1:0]       run_d;
        logic [1:0]       pwm;
        logic [1:0]       pin;
        logic [1:0]       to_p;
        logic [1:0]       mtrig;
        logic [4:0]       raw;
        logic             chain;
        logic             dma;
        logic [2:0]       sync;
        logic             lvl;
    } state_t;
endpackage

// ==== tb/chain_dma_peer.sv ====
// Far side: preceding chained timer and DMA controller
`timescale 1ns/1ps
module chain_dma_peer (
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       fire,
    input  wire logic       dma_req,
    output logic            chain_trigger_in,
    output logic [7:0]      dma_bursts
);
    // ========================================
    // Predecessor time-out pulse, burst count
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            chain_trigger_in <= 1'b0;
            dma_bursts       <= 8'h00;
        end else begin
            chain_trigger_in <= fire;
            if (dma_req) begin
                dma_bursts <= dma_bursts + 8'h01;
            end
        end
    end
endmodule

// ==== tb/tb.sv ====
// Testbench for the general-purpose timer
`timescale 1ns/1ps
module tb;
    import gp_timer_pkg::*;
    logic              clk, arst_n, ce, fire, irq, dma_req;
    logic              chain_trigger_in, chain_trigger_out;
    logic [2:0]        width_config;
    logic [1:0]        counter_run_bit, alt_mode_select, capture_kind_select;
    logic [1:0]        wait_chain_trigger_bit, snapshot_at_timeout;
    logic [1:0]        match_trigger_enable, match_irq_enable;
    logic [1:0]        count_direction, pwm_output_invert, match_trigger;
    logic [1:0]        capture_compare_pin_i, capture_compare_pin_o;
    logic [1:0]        capture_compare_pin_oe;
    logic [1:0][1:0]   timer_mode_field;
    logic [1:0][7:0]   prescale_value;
    logic [31:0]       interval_load_a, match_value_a, count_a, count_b;
    logic [31:0]       snapshot_a, snapshot_b;
    logic [15:0]       interval_load_b, match_value_b;
    logic [4:0]        irq_mask_word, irq_clear_word;
    logic [4:0]        raw_irq_flags, masked_irq_flags;
    logic [7:0]        dma_bursts;
    int                mismatches, n_compared;
    logic [31:0]       hi;

    gp_timer dut (.*);
    chain_dma_peer peer (.clk(clk), .arst_n(arst_n), .fire(fire),
        .dma_req(dma_req), .chain_trigger_in(chain_trigger_in),
        .dma_bursts(dma_bursts));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // ========================================
    // Tasks
    task automatic defaults();
        ce <= 1'b1; fire <= 1'b0; width_config <= CFG_32;
        counter_run_bit <= '0; alt_mode_select <= '0;
        capture_kind_select <= '0; wait_chain_trigger_bit <= '0;
        snapshot_at_timeout <= '0; match_trigger_enable <= '0;
        match_irq_enable <= '0; count_direction <= '0;
        pwm_output_invert <= '0; capture_compare_pin_i <= '0;
        timer_mode_field <= '0; prescale_value <= '0;
        interval_load_a <= '0; match_value_a <= '0;
        interval_load_b <= '0; match_value_b <= '0;
        irq_mask_word <= '0; irq_clear_word <= '0;
    endtask
    task automatic rst();
        @(posedge clk);
        arst_n <= 1'b0;
        defaults();
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic results();
        if (mismatches == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (3000) @(posedge clk);
        mismatches++;
        results();
    end
    // ========================================
    // Tests
    initial begin
        arst_n <= 1'b0;
        defaults();
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        tick(1);
        chk({capture_compare_pin_o, raw_irq_flags, irq}, 8'h00);
        @(posedge clk);
        interval_load_a <= 32'h2;
        timer_mode_field[0] <= MODE_PER;
        irq_mask_word <= 5'h01;
        @(posedge clk) counter_run_bit <= 2'h1;
        for (int i = 0; i < 3; i++) begin
            tick(1);
            chk(count_a, 32'h2 - i);
        end
        tick(1);
        chk(count_a, 32'h2);
        chk({raw_irq_flags, masked_irq_flags}, 10'h021);
        chk({dma_req, chain_trigger_out, irq}, 3'h7);
        @(posedge clk);
        counter_run_bit <= 2'h0;
        #1;
        chk({dma_req, chain_trigger_out, raw_irq_flags}, 7'h01);
        @(posedge clk) irq_clear_word <= 5'h01;
        @(posedge clk) irq_clear_word <= 5'h00;
        tick(1);
        chk({raw_irq_flags, irq}, 6'h00);
        chk(dma_bursts, 8'h01);
        // One-shot stops after time-out
        rst();
        interval_load_a <= 32'h2;
        timer_mode_field[0] <= MODE_ONE;
        @(posedge clk) counter_run_bit <= 2'h1;
        tick(6);
        chk(count_a, 32'h2);
        chk(raw_irq_flags[IX_TO_A], 1'b1);
        // Match flag, trigger and DMA while counting goes on
        rst();
        interval_load_a <= 32'h4;
        match_value_a <= 32'h2;
        timer_mode_field[0] <= MODE_PER;
        match_irq_enable <= 2'h1;
        match_trigger_enable <= 2'h1;
        @(posedge clk) counter_run_bit <= 2'h1;
        tick(3);
        chk(count_a, 32'h2);
        tick(1);
        chk(count_a, 32'h1);
        chk(raw_irq_flags, 5'h02);
        chk(masked_irq_flags, 5'h00);
        chk({dma_req, irq, match_trigger}, 4'h9);
        // Up count
        rst();
        interval_load_a <= 32'h5;
        count_direction <= 2'h1;
        snapshot_at_timeout <= 2'h1;
        timer_mode_field[0] <= MODE_PER;
        @(posedge clk) counter_run_bit <= 2'h1;
        tick(3);
        chk(count_a, 32'h2);
        // Clock enable low freezes the count
        @(posedge clk) ce <= 1'b0;
        tick(3);
        chk(count_a, 32'h3);
        @(posedge clk) ce <= 1'b1;
        tick(3);
        chk(snapshot_a, 32'h5);
        chk(count_a, 32'h0);
        // PWM, plain then inverted; prescaler must be ignored
        rst();
        width_config <= CFG_16;
        alt_mode_select <= 2'h1;
        timer_mode_field[0] <= MODE_PWM;
        interval_load_a <= 32'h4;
        match_value_a <= 32'h1;
        prescale_value[0] <= 8'h3;
        for (int v = 0; v < 2; v++) begin
            @(posedge clk) pwm_output_invert <= 2'(v);
            @(posedge clk) counter_run_bit <= 2'h1;
            tick(3);
            hi = 0;
            for (int i = 0; i < 10; i++) begin
                hi += 32'(capture_compare_pin_o[0]);
                tick(1);
            end
            chk(hi, (v == 1) ? 32'h4 : 32'h6);
            chk({capture_compare_pin_oe[0], raw_irq_flags}, 6'h20);
            chk({dma_bursts, irq}, 9'h000);
            @(posedge clk) counter_run_bit <= 2'h0;
            tick(3);
            chk(capture_compare_pin_o[0], 32'(v));
        end
        // Wait for chain trigger in one-shot and periodic
        for (int m = 1; m < 3; m++) begin
            rst();
            timer_mode_field[0] <= 2'(m);
            interval_load_a <= 32'h5;
            wait_chain_trigger_bit <= 2'h1;
            @(posedge clk) counter_run_bit <= 2'h1;
            tick(4);
            chk(count_a, 32'h5);
            @(posedge clk) fire <= 1'b1;
            @(posedge clk) fire <= 1'b0;
            tick(3);
            chk(count_a, 32'h3);
        end
        // 16-bit halves: A triggers B
        rst();
        width_config <= CFG_16;
        timer_mode_field <= {MODE_PER, MODE_PER};
        interval_load_a <= 32'h2;
        interval_load_b <= 16'h3;
        wait_chain_trigger_bit <= 2'h2;
        @(posedge clk) counter_run_bit <= 2'h3;
        tick(4);
        chk(count_b, 32'h3);
        chk(chain_trigger_out, 1'b0);
        tick(4);
        chk(count_b, 32'h0);
        tick(1);
        chk(chain_trigger_out, 1'b1);
        tick(1);
        chk(chain_trigger_out, 1'b0);
        // 16-bit count stretched by the prescaler
        rst();
        width_config <= CFG_16;
        timer_mode_field[0] <= MODE_PER;
        interval_load_a <= 32'h4;
        prescale_value[0] <= 8'h2;
        @(posedge clk) counter_run_bit <= 2'h1;
        tick(6);
        chk(count_a, 32'h3);
        tick(3);
        chk(count_a, 32'h2);
        // RTC counts edges of pin 0
        rst();
        width_config <= CFG_RTC;
        match_value_a <= 32'h3;
        irq_mask_word <= 5'h04;
        @(posedge clk) counter_run_bit <= 2'h1;
        for (int i = 0; i < 5; i++) begin
            @(posedge clk) capture_compare_pin_i <= 2'h1;
            repeat (8) @(posedge clk);
            capture_compare_pin_i <= 2'h0;
            repeat (7) @(posedge clk);
        end
        tick(8);
        chk(count_a, 32'h5);
        chk({raw_irq_flags, irq}, 6'h09);
        @(posedge clk) irq_clear_word <= 5'h04;
        @(posedge clk) irq_clear_word <= 5'h00;
        tick(1);
        chk(raw_irq_flags, 5'h00);
        results();
    end
endmodule
